// ---- hw/aevc_counter.v ----
`timescale 1ns/1ns
`default_nettype none
`include "aevc_regs.vh"

module aevc_counter (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire upper_event_pin,
	input wire lower_event_pin,
	input wire sleep_mode,
	input wire hold_mode,
	input wire module_standby,
	output reg irq
);

	// Counting is done by sampling both event pins on aclk, so aclk must keep
	// running while events arrive; a pin must stay high and low for at least
	// two aclk periods or an event is lost.
	// Chained and split modes share one datapath: the only difference is what
	// steps the upper counter and which flags a wrap may set.
	// The counters change under a running read, so software closes both gates
	// first and accepts that each counter may still move by one.
	// Power modes arrive as levels from logic on aclk and are used as they are.

	// Pin synchronisers; index 1 is the upper pin, index 0 the lower pin.
	reg [1:0] pin_s1_reg;
	reg [1:0] pin_s2_reg;
	reg [1:0] pin_s3_reg;
	reg [1:0] pin_level_reg;
	wire [1:0] pin_agree;
	wire [1:0] pin_rise;

	// Software visible state.
	reg [7:0] counter_ctrl_status_reg;
	reg [7:0] upper_count_reg;
	reg [7:0] lower_count_reg;
	reg counter_irq_pending;
	reg counter_irq_enable;

	// Write channel holding state.
	reg aw_held_reg;
	reg w_held_reg;
	reg [7:0] waddr_reg;
	reg [7:0] wdata_reg;
	reg wstrb0_reg;

	// Decoded control fields.
	wire split_channel_select;
	wire upper_count_gate;
	wire lower_count_gate;
	wire upper_reset_release;
	wire lower_reset_release;
	wire upper_overflow_flag;
	wire lower_overflow_flag;

	// Counting terms.
	wire lower_active;
	wire upper_active;
	wire lower_step;
	wire lower_carry;
	wire upper_source;
	wire upper_step;
	wire upper_wrap;
	wire flags_frozen;
	wire upper_ovf_set;
	wire lower_ovf_set;
	wire ovf_event;

	// Write decode terms.
	wire do_write;
	wire wr_ctrl;
	wire wr_pend;
	wire wr_en;
	wire wr_hit;
	wire ctrl_writable;
	reg [7:0] ctrl_next;
	reg [7:0] upper_next;
	reg [7:0] lower_next;
	reg [31:0] rdata_next;
	reg rresp_err_next;

	// Three flip-flops per pin; the first stage feeds only the second.
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_reg <= 2'b00;
			pin_s2_reg <= 2'b00;
			pin_s3_reg <= 2'b00;
		end else begin
			pin_s1_reg <= {upper_event_pin, lower_event_pin};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	// A pin change counts only once stages two and three agree, which
	// rejects a level that settled late in the first stage.
	assign pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
	assign pin_rise = pin_agree & pin_s2_reg & ~pin_level_reg;

	// Accepted pin level, used to find rising edges.
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_level_reg <= 2'b00;
		end else begin
			pin_level_reg <= (pin_agree & pin_s2_reg) | (~pin_agree & pin_level_reg);
		end
	end

	// Field views of the control/status register.
	assign split_channel_select = counter_ctrl_status_reg[`AEVC_BIT_SPLIT];
	assign upper_count_gate = counter_ctrl_status_reg[`AEVC_BIT_UPPER_GATE];
	assign lower_count_gate = counter_ctrl_status_reg[`AEVC_BIT_LOWER_GATE];
	assign upper_reset_release = counter_ctrl_status_reg[`AEVC_BIT_UPPER_REL];
	assign lower_reset_release = counter_ctrl_status_reg[`AEVC_BIT_LOWER_REL];
	assign upper_overflow_flag = counter_ctrl_status_reg[`AEVC_BIT_UPPER_OVF];
	assign lower_overflow_flag = counter_ctrl_status_reg[`AEVC_BIT_LOWER_OVF];

	// A counter advances only when released, gated open and not in
	// module standby. Counting is driven by pin edges alone, so it goes on
	// whatever the core's power mode is.
	assign lower_active = lower_reset_release & lower_count_gate & ~module_standby;
	assign upper_active = upper_reset_release & upper_count_gate & ~module_standby;

	// The lower counter always takes the lower pin.
	assign lower_step = lower_active & pin_rise[0];
	assign lower_carry = lower_step & (lower_count_reg == `AEVC_COUNT_FULL);

	// The upper counter takes its own pin when split, else the lower carry.
	// In chained mode the upper gate must stand open when the lower
	// counter wraps, or that carry is lost.
	assign upper_source = split_channel_select ? pin_rise[1] : lower_carry;
	assign upper_step = upper_active & upper_source;
	assign upper_wrap = upper_step & (upper_count_reg == `AEVC_COUNT_FULL);

	// In sleep, watch and standby the counters run but flags are frozen.
	assign flags_frozen = sleep_mode | hold_mode;

	// Chained: the upper flag marks the 16-bit wrap; split: each its own.
	assign upper_ovf_set = upper_wrap & ~flags_frozen;
	assign lower_ovf_set = split_channel_select & lower_carry & ~flags_frozen;
	assign ovf_event = upper_ovf_set | lower_ovf_set;

	// A write is performed once both address and data are held.
	assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
	assign wr_ctrl = do_write & wstrb0_reg & (waddr_reg == `AEVC_OFS_CTRL);
	assign wr_pend = do_write & wstrb0_reg & (waddr_reg == `AEVC_OFS_IRQ_PEND);
	assign wr_en = do_write & wstrb0_reg & (waddr_reg == `AEVC_OFS_IRQ_EN);

	// Watch, standby and module standby keep the register as it is;
	// sleep leaves it writable.
	assign ctrl_writable = ~hold_mode & ~module_standby;

	// Writes only clear the flags; a flag set in the same cycle wins.
	always @* begin
		ctrl_next = counter_ctrl_status_reg;
		if (wr_ctrl && ctrl_writable) begin
			ctrl_next = {wdata_reg[7] & upper_overflow_flag,
				wdata_reg[6] & lower_overflow_flag, 1'b0, wdata_reg[4:0]};
		end
		if (upper_ovf_set) begin
			ctrl_next[`AEVC_BIT_UPPER_OVF] = 1'b1;
		end
		if (lower_ovf_set) begin
			ctrl_next[`AEVC_BIT_LOWER_OVF] = 1'b1;
		end
	end

	// Control/status register, zero after reset.
	always @(posedge aclk) begin
		if (!aresetn) begin
			counter_ctrl_status_reg <= `AEVC_RST_CTRL;
		end else begin
			counter_ctrl_status_reg <= ctrl_next;
		end
	end

	// Counter next values; a cleared release bit holds the counter at zero.
	// Software reading while gates close may see one extra count.
	always @* begin
		lower_next = lower_count_reg;
		upper_next = upper_count_reg;
		if (!lower_reset_release) begin
			lower_next = `AEVC_RST_COUNT;
		end else if (lower_step) begin
			lower_next = lower_count_reg + 8'h01;
		end
		if (!upper_reset_release) begin
			upper_next = `AEVC_RST_COUNT;
		end else if (upper_step) begin
			upper_next = upper_count_reg + 8'h01;
		end
	end

	// Both counters wrap to zero and keep counting.
	always @(posedge aclk) begin
		if (!aresetn) begin
			lower_count_reg <= `AEVC_RST_COUNT;
			upper_count_reg <= `AEVC_RST_COUNT;
		end else begin
			lower_count_reg <= lower_next;
			upper_count_reg <= upper_next;
		end
	end

	// Pending bit: cleared by writing zero, set wins. It is not cleared when
	// the request is taken.
	always @(posedge aclk) begin
		if (!aresetn) begin
			counter_irq_pending <= 1'b0;
		end else if (ovf_event) begin
			counter_irq_pending <= 1'b1;
		end else if (wr_pend && !wdata_reg[`AEVC_BIT_IRQ]) begin
			counter_irq_pending <= 1'b0;
		end
	end

	// Interrupt enable register.
	always @(posedge aclk) begin
		if (!aresetn) begin
			counter_irq_enable <= 1'b0;
		end else if (wr_en) begin
			counter_irq_enable <= wdata_reg[`AEVC_BIT_IRQ];
		end
	end

	// The request reaches the CPU only while enabled.
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= counter_irq_pending & counter_irq_enable;
		end
	end

	// Address and data are taken in either order and held until the
	// write is performed; one write is under way at a time.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			waddr_reg <= 8'h00;
			wdata_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
		end else begin
			s_axi_awready <= ~aw_held_reg & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready <= ~w_held_reg & ~(s_axi_wvalid & s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				waddr_reg <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
			end else if (do_write) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	// Any decoded offset is a hit; read-only counters accept writes silently.
	assign wr_hit = (waddr_reg == `AEVC_OFS_CTRL) | (waddr_reg == `AEVC_OFS_UPPER) |
		(waddr_reg == `AEVC_OFS_LOWER) | (waddr_reg == `AEVC_OFS_IRQ_PEND) |
		(waddr_reg == `AEVC_OFS_IRQ_EN);

	// Write response one cycle after both halves are held.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `AEVC_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? `AEVC_RESP_OKAY : `AEVC_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read decode; narrow registers sit in the low byte.
	always @* begin
		rdata_next = 32'h0000_0000;
		rresp_err_next = 1'b0;
		if (s_axi_araddr == `AEVC_OFS_CTRL) begin
			rdata_next[7:0] = counter_ctrl_status_reg;
		end else if (s_axi_araddr == `AEVC_OFS_UPPER) begin
			rdata_next[7:0] = upper_count_reg;
		end else if (s_axi_araddr == `AEVC_OFS_LOWER) begin
			rdata_next[7:0] = lower_count_reg;
		end else if (s_axi_araddr == `AEVC_OFS_IRQ_PEND) begin
			rdata_next[`AEVC_BIT_IRQ] = counter_irq_pending;
		end else if (s_axi_araddr == `AEVC_OFS_IRQ_EN) begin
			rdata_next[`AEVC_BIT_IRQ] = counter_irq_enable;
		end else begin
			rresp_err_next = 1'b1;
		end
	end

	// Read channel: the address is taken when ready, data follows next cycle.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `AEVC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdata_next;
			s_axi_rresp <= rresp_err_next ? `AEVC_RESP_SLVERR : `AEVC_RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

endmodule // aevc_counter

`default_nettype wire

// ---- inc/aevc_regs.vh ----
// Summary of operation
// - Count event pin edges sampled on aclk.
// - Control/status register: 8-bit, RW, resets zero.
// - Upper counter: upper pin or lower carry.
// - Lower counter always clocked by lower pin.
// - Chained gives 16 bits; split gives two 8-bit.
// - Counters software-clearable, reset zero, always readable.
// - Channel select resets zero, chained after reset.
// - Chained wrap from all ones sets upper flag.
// - Overflow sets pending; enable gates CPU request.
// - Pending stays set until software writes zero.
// - Low power: count, flags frozen, register held except in sleep.
// - Module standby halts counters, keeps register.
// - Software stops gates before reading; one slip.
// - Channel select at bit four, one splits.
// - Overflow flags: bit seven upper, six lower.
// - Count gates; lower at bit two, zero blocks.
// - Reset releases at bits one and zero.
`ifndef AEVC_REGS_VH
`define AEVC_REGS_VH

// Register byte offsets on the register bus.
`define AEVC_OFS_CTRL 8'h00
`define AEVC_OFS_UPPER 8'h04
`define AEVC_OFS_LOWER 8'h08
`define AEVC_OFS_IRQ_PEND 8'h0C
`define AEVC_OFS_IRQ_EN 8'h10

// Field positions in the control/status register.
`define AEVC_BIT_UPPER_OVF 7
`define AEVC_BIT_LOWER_OVF 6
`define AEVC_BIT_SPLIT 4
`define AEVC_BIT_UPPER_GATE 3
`define AEVC_BIT_LOWER_GATE 2
`define AEVC_BIT_UPPER_REL 1
`define AEVC_BIT_LOWER_REL 0

// Position of the single bit in the pending and enable registers.
`define AEVC_BIT_IRQ 0

// Reset values.
`define AEVC_RST_CTRL 8'h00
`define AEVC_RST_COUNT 8'h00
`define AEVC_COUNT_FULL 8'hFF

// Bus answers.
`define AEVC_RESP_OKAY 2'b00
`define AEVC_RESP_SLVERR 2'b10

`endif

// ---- verif/aevc_counter_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module aevc_counter_mon (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic irq
);
	// Everything here lives in the bus clock domain.
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Address and data of a write taken together.
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// A read aimed past the last register.
	sequence s_rd_hole;
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10;
	endsequence
	a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("address taken twice");
	a_w_refused: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
		else $error("data taken twice");
	a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_rd_hole: assert property (s_rd_hole |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
		else $error("hole read not refused");
	a_byte_wide: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	a_irq_clear: assert property ($fell(irq) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
		else $error("irq fell without a write");
endmodule // aevc_counter_mon
bind aevc_counter aevc_counter_mon u_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .irq);
`default_nettype wire

// ---- verif/aevc_pulse_src.sv ----
`timescale 1ns/1ns
`default_nettype none
// Stands in for an outside event source on one pin; idle low between bursts.
module aevc_pulse_src (
	output var logic pin
);
	// Each event is 60 ns high and 65 ns low, a 125 ns period with no tie to aclk.
	task burst(input int n);
		repeat (n) begin
			#65 pin = 1'b1;
			#60 pin = 1'b0;
		end
	endtask
	// A low start level keeps the first rising edge a real event.
	initial pin = 1'b0;
endmodule // aevc_pulse_src
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic sleep_mode, hold_mode, module_standby, irq, upper_event_pin, lower_event_pin;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp, brsp;
	int n_fail = 0;
	int n_tests = 0;
	aevc_counter u_aevc_counter (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .upper_event_pin, .lower_event_pin, .sleep_mode,
		.hold_mode, .module_standby, .irq);
	aevc_pulse_src u_lo (.pin(lower_event_pin));
	aevc_pulse_src u_hi (.pin(upper_event_pin));
	// The 100 MHz bus clock.
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task results;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// Write one byte; each channel is dropped only once it has been taken.
	task wr(input logic [7:0] a, input logic [7:0] v);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'hA5_A5A5, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) begin
				ta = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready) begin
				tw = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(ta && tw));
		while (!s_axi_bvalid) @(posedge aclk);
		brsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// Read one word into d and its response code into rsp.
	task rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge aclk);
		d = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task rc(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk(d, {24'h00_0000, e});
	endtask
	// The irq line trails the register write by a cycle, so let two edges pass.
	task ci(input logic e);
		repeat (2) @(posedge aclk);
		#1;
		chk({31'h0000_0000, irq}, {31'h0000_0000, e});
	endtask
	// Offsets: 00 control, 04 upper, 08 lower, 0C pending, 10 enable.
	task t_reset;
		rc(8'h00, 8'h00);
		rc(8'h04, 8'h00);
		wr(8'h08, 8'hFF);
		chk({30'h0000_0000, brsp}, {30'h0000_0000, 2'b00});
		rc(8'h08, 8'h00);
		s_axi_wstrb <= 4'hE;
		wr(8'h00, 8'h1F);
		s_axi_wstrb <= 4'hF;
		rc(8'h00, 8'h00);
		wr(8'h14, 8'h00);
		chk({30'h0000_0000, brsp}, {30'h0000_0000, 2'b10});
		rd(8'h14);
		chk({30'h0000_0000, rsp}, {30'h0000_0000, 2'b10});
	endtask
	// 300 lower events carry once into the upper half; upper pin is ignored.
	task t_chain;
		wr(8'h10, 8'h01);
		wr(8'h00, 8'h0F);
		fork
			u_lo.burst(300);
			u_hi.burst(5);
		join
		wr(8'h00, 8'h03);
		rc(8'h04, 8'h01);
		rc(8'h08, 8'h2C);
		rc(8'h00, 8'h03);
		ci(1'b0);
	endtask
	// Both halves wrap on their own pins, then the interrupt is unmasked and cleared.
	task t_split;
		wr(8'h10, 8'h00);
		wr(8'h00, 8'h10);
		rc(8'h08, 8'h00);
		wr(8'h00, 8'h1F);
		fork
			u_lo.burst(256);
			u_hi.burst(259);
		join
		wr(8'h00, 8'hD3);
		rc(8'h00, 8'hD3);
		rc(8'h08, 8'h00);
		rc(8'h04, 8'h03);
		rc(8'h0C, 8'h01);
		ci(1'b0);
		wr(8'h10, 8'h01);
		ci(1'b1);
		rc(8'h10, 8'h01);
		wr(8'h0C, 8'h00);
		ci(1'b0);
	endtask
	// Low power counts without flags; module standby and a closed gate stop counting.
	task t_power;
		wr(8'h00, 8'h1F);
		@(posedge aclk);
		sleep_mode <= 1'b1;
		u_lo.burst(258);
		@(posedge aclk);
		sleep_mode <= 1'b0;
		wr(8'h00, 8'h13);
		rc(8'h00, 8'h13);
		rc(8'h08, 8'h02);
		rc(8'h0C, 8'h00);
		@(posedge aclk);
		hold_mode <= 1'b1;
		wr(8'h00, 8'h1F);
		rc(8'h00, 8'h13);
		@(posedge aclk);
		hold_mode <= 1'b0;
		wr(8'h00, 8'h1F);
		@(posedge aclk);
		module_standby <= 1'b1;
		u_lo.burst(4);
		wr(8'h00, 8'h00);
		rc(8'h00, 8'h1F);
		rc(8'h08, 8'h02);
		@(posedge aclk);
		module_standby <= 1'b0;
		wr(8'h00, 8'h13);
		u_lo.burst(3);
		rc(8'h08, 8'h02);
	endtask
	// Reset for two cycles, then the scenarios in turn.
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{sleep_mode, hold_mode, module_standby} = 3'h0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hF;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_chain;
		t_split;
		t_power;
		results;
	end
	// The scenarios need about 10,500 cycles; the guard allows 30,000.
	initial begin
		#300_000;
		n_fail++;
		results;
	end
endmodule // testbench
`default_nettype wire
